// file: uif_uart_irq.sv
// Purpose: uart irq enable/identify, line status, baud
// Assumes: receiver and transmitter cores on sys_clk drive the core-side ports
// Notes: read data appear in the cycle after the read strobe
`timescale 1ns/10ps

module uif_uart_irq #(
    parameter int DL_W = 16,
    parameter int CD_W = 3,
    parameter int N_W = 11
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [uif_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [uif_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [uif_pkg::DATA_W-1:0] reg_rdata,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_parity_err,
    input wire logic rx_frame_err,
    input wire logic rx_break,
    input wire logic tx_take,
    input wire logic tx_shift_busy,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic baud_tick,
    output logic uart_irq,
    output logic evt_irq
);

    // ------------------------
    // address decode
    // ------------------------
    function automatic logic hit(
        input logic [uif_pkg::ADDR_W-1:0] addr,
        input logic [uif_pkg::ADDR_W-1:0] offset
    );
        hit = (addr == offset);
    endfunction : hit

    logic wr_data;
    logic wr_enable;
    logic wr_frac;
    logic wr_std;
    logic wr_evt_clear;
    logic wr_evt_enable;
    logic rd_data;
    logic rd_ident;
    logic rd_line;

    assign wr_data = reg_wr && hit(reg_addr, uif_pkg::ADDR_DATA);
    assign wr_enable = reg_wr && hit(reg_addr, uif_pkg::ADDR_IRQ_ENABLE);
    assign wr_frac = reg_wr && hit(reg_addr, uif_pkg::ADDR_FRAC_DIVIDER);
    assign wr_std = reg_wr && hit(reg_addr, uif_pkg::ADDR_STD_DIVIDER);
    assign wr_evt_clear = reg_wr && hit(reg_addr, uif_pkg::ADDR_EVT_CLEAR);
    assign wr_evt_enable = reg_wr && hit(reg_addr, uif_pkg::ADDR_EVT_ENABLE);
    assign rd_data = reg_rd && hit(reg_addr, uif_pkg::ADDR_DATA);
    assign rd_ident = reg_rd && hit(reg_addr, uif_pkg::ADDR_IRQ_IDENTIFY);
    assign rd_line = reg_rd && hit(reg_addr, uif_pkg::ADDR_LINE_STATUS);

    // ------------------------
    // configuration registers
    // ------------------------
    logic [2:0] irq_enable_q;
    logic [15:0] frac_divider_q;
    logic [DL_W-1:0] std_dl_q;
    logic [CD_W-1:0] std_cd_q;

    // only bits 2:0 are kept; 7:3 read as zero
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_enable_q <= uif_pkg::IRQ_ENABLE_RST[2:0];
        end else if (clk_en && wr_enable) begin
            irq_enable_q <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            frac_divider_q <= uif_pkg::FRAC_DIVIDER_RST;
        end else if (clk_en && wr_frac) begin
            frac_divider_q <= reg_wdata[15:0];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            std_dl_q <= DL_W'(uif_pkg::STD_DL_RST);
            std_cd_q <= CD_W'(uif_pkg::STD_CD_RST);
        end else if (clk_en && wr_std) begin
            std_dl_q <= reg_wdata[DL_W-1:0];
            std_cd_q <= reg_wdata[uif_pkg::STD_CD_LO +: CD_W];
        end
    end

    // ------------------------
    // receive side: data and line status
    // ------------------------
    logic [7:0] rx_data_q;
    logic data_ready_q;
    logic overrun_q;
    logic parity_error_q;
    logic framing_error_q;
    logic break_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_data_q <= uif_pkg::BYTE_ZERO;
        end else if (clk_en && rx_valid) begin
            rx_data_q <= rx_byte;
        end
    end

    // a new character in the read cycle keeps ready set
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            data_ready_q <= 1'b0;
        end else if (clk_en) begin
            if (rx_valid) begin
                data_ready_q <= 1'b1;
            end else if (rd_data) begin
                data_ready_q <= 1'b0;
            end
        end
    end

    // errors clear on a line status read unless a new one lands then
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            overrun_q <= 1'b0;
            parity_error_q <= 1'b0;
            framing_error_q <= 1'b0;
            break_q <= 1'b0;
        end else if (clk_en) begin
            if (rx_valid && data_ready_q && !rd_data) begin
                overrun_q <= 1'b1;
            end else if (rd_line) begin
                overrun_q <= 1'b0;
            end
            if (rx_valid && rx_parity_err) begin
                parity_error_q <= 1'b1;
            end else if (rd_line) begin
                parity_error_q <= 1'b0;
            end
            if (rx_valid && rx_frame_err) begin
                framing_error_q <= 1'b1;
            end else if (rd_line) begin
                framing_error_q <= 1'b0;
            end
            if (rx_break) begin
                break_q <= 1'b1;
            end else if (rd_line) begin
                break_q <= 1'b0;
            end
        end
    end

    // ------------------------
    // transmit side: holding register
    // ------------------------
    logic holding_empty_q;
    logic tx_holding_empty_pend_q;
    logic [1:0] src_code;

    // a write beside a take refills the register, so empty stays low
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            holding_empty_q <= 1'b1;
            tx_valid <= 1'b0;
            tx_byte <= uif_pkg::BYTE_ZERO;
        end else if (clk_en) begin
            if (wr_data) begin
                holding_empty_q <= 1'b0;
                tx_valid <= 1'b1;
                tx_byte <= reg_wdata[7:0];
            end else if (tx_take) begin
                holding_empty_q <= 1'b1;
                tx_valid <= 1'b0;
            end
        end
    end

    // pending flag arms on an empty edge or on enabling while empty
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_holding_empty_pend_q <= 1'b0;
        end else if (clk_en) begin
            if (!wr_data && tx_take && !holding_empty_q) begin
                tx_holding_empty_pend_q <= 1'b1;
            end else if (wr_enable && reg_wdata[uif_pkg::EN_TX_EMPTY]
                         && !irq_enable_q[uif_pkg::EN_TX_EMPTY] && holding_empty_q) begin
                tx_holding_empty_pend_q <= 1'b1;
            end else if (wr_data) begin
                tx_holding_empty_pend_q <= 1'b0;
            end else if (rd_ident && src_code == uif_pkg::SRC_TX_EMPTY) begin
                tx_holding_empty_pend_q <= 1'b0;
            end
        end
    end

    // ------------------------
    // interrupt identification
    // ------------------------
    logic line_pend;
    logic rx_pend;
    logic tx_pend;
    logic any_pend;
    logic [7:0] ident_value;

    assign line_pend = irq_enable_q[uif_pkg::EN_LINE]
                       && (overrun_q || parity_error_q || framing_error_q);
    assign rx_pend = irq_enable_q[uif_pkg::EN_RX_FULL] && data_ready_q;
    assign tx_pend = irq_enable_q[uif_pkg::EN_TX_EMPTY] && tx_holding_empty_pend_q;
    assign any_pend = line_pend || rx_pend || tx_pend;

    always_comb begin
        if (line_pend) begin
            src_code = uif_pkg::SRC_LINE;
        end else if (rx_pend) begin
            src_code = uif_pkg::SRC_RX_FULL;
        end else if (tx_pend) begin
            src_code = uif_pkg::SRC_TX_EMPTY;
        end else begin
            src_code = uif_pkg::SRC_NONE;
        end
    end

    assign ident_value = {5'h00, src_code, !any_pend};

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            uart_irq <= 1'b0;
        end else if (clk_en) begin
            uart_irq <= any_pend;
        end
    end

    // ------------------------
    // sticky event status, clear and enable
    // ------------------------
    logic [uif_pkg::EVT_W-1:0] evt_status_q;
    logic [uif_pkg::EVT_W-1:0] evt_enable_q;
    logic [uif_pkg::EVT_W-1:0] evt_set;

    assign evt_set[uif_pkg::EVT_RX] = rx_valid;
    assign evt_set[uif_pkg::EVT_TX] = tx_take && !holding_empty_q;
    assign evt_set[uif_pkg::EVT_LINE] = rx_valid
                                        && (rx_parity_err || rx_frame_err
                                            || (data_ready_q && !rd_data));

    // set beats a clear written in the same cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            evt_status_q <= uif_pkg::EVT_ZERO;
        end else if (clk_en) begin
            evt_status_q <= (evt_status_q & ~(wr_evt_clear ? reg_wdata[uif_pkg::EVT_W-1:0]
                                                           : uif_pkg::EVT_ZERO)) | evt_set;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            evt_enable_q <= uif_pkg::EVT_ZERO;
        end else if (clk_en && wr_evt_enable) begin
            evt_enable_q <= reg_wdata[uif_pkg::EVT_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            evt_irq <= 1'b0;
        end else if (clk_en) begin
            evt_irq <= |(evt_status_q & evt_enable_q);
        end
    end

    // ------------------------
    // read data
    // ------------------------
    logic [7:0] line_value;
    logic [uif_pkg::DATA_W-1:0] rd_mux;

    always_comb begin
        line_value = uif_pkg::BYTE_ZERO;
        line_value[uif_pkg::LS_DR] = data_ready_q;
        line_value[uif_pkg::LS_OE] = overrun_q;
        line_value[uif_pkg::LS_PE] = parity_error_q;
        line_value[uif_pkg::LS_FE] = framing_error_q;
        line_value[uif_pkg::LS_BI] = break_q;
        line_value[uif_pkg::LS_TX_HOLDING_EMPTY] = holding_empty_q;
        line_value[uif_pkg::LS_TEMT] = holding_empty_q && !tx_shift_busy;
    end

    // unmapped and write-only addresses read zero
    always_comb begin
        rd_mux = '0;
        unique case (1'b1)
            hit(reg_addr, uif_pkg::ADDR_DATA): rd_mux[7:0] = rx_data_q;
            hit(reg_addr, uif_pkg::ADDR_IRQ_ENABLE): rd_mux[2:0] = irq_enable_q;
            hit(reg_addr, uif_pkg::ADDR_IRQ_IDENTIFY): rd_mux[7:0] = ident_value;
            hit(reg_addr, uif_pkg::ADDR_LINE_STATUS): rd_mux[7:0] = line_value;
            hit(reg_addr, uif_pkg::ADDR_FRAC_DIVIDER): rd_mux[15:0] = frac_divider_q;
            hit(reg_addr, uif_pkg::ADDR_STD_DIVIDER): begin
                rd_mux[DL_W-1:0] = std_dl_q;
                rd_mux[uif_pkg::STD_CD_LO +: CD_W] = std_cd_q;
            end
            hit(reg_addr, uif_pkg::ADDR_EVT_STATUS): rd_mux[uif_pkg::EVT_W-1:0] = evt_status_q;
            hit(reg_addr, uif_pkg::ADDR_EVT_ENABLE): rd_mux[uif_pkg::EVT_W-1:0] = evt_enable_q;
            default: rd_mux = '0;
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

    // ------------------------
    // baud generation
    // ------------------------
    uif_baud_gen #(
        .DL_W(DL_W),
        .CD_W(CD_W),
        .N_W(N_W)
    ) u_baud_gen (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .frac_en(frac_divider_q[uif_pkg::FRAC_EN_BIT]),
        .cd(std_cd_q),
        .dl(std_dl_q),
        .frac_m_field(frac_divider_q[uif_pkg::FRAC_M_HI:uif_pkg::FRAC_M_LO]),
        .frac_numerator(frac_divider_q[uif_pkg::FRAC_N_HI:0]),
        .baud_tick(baud_tick)
    );

endmodule : uif_uart_irq

// file: uif_pkg.sv
// Purpose: shared constants for the uart interrupt and fractional baud block
// Assumes: 32-bit byte addresses, 32-bit read data, 8/16-bit registers in low bits, except the std divider with cd in bits 18:16
// Notes: addresses are byte addresses; all are word aligned

package uif_pkg;

    // ------------------------
    // widths
    // ------------------------
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int EVT_W = 3;

    // ------------------------
    // register map
    // ------------------------
    localparam logic [ADDR_W-1:0] ADDR_DATA = 32'hffff0800;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 32'h0fff0804;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_IDENTIFY = 32'hffff0808;
    localparam logic [ADDR_W-1:0] ADDR_LINE_STATUS = 32'hffff0814;
    localparam logic [ADDR_W-1:0] ADDR_FRAC_DIVIDER = 32'hffff082c;
    localparam logic [ADDR_W-1:0] ADDR_STD_DIVIDER = 32'hffff0840;
    localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = 32'hffff0850;
    localparam logic [ADDR_W-1:0] ADDR_EVT_CLEAR = 32'hffff0854;
    localparam logic [ADDR_W-1:0] ADDR_EVT_ENABLE = 32'hffff0858;

    // ------------------------
    // reset values
    // ------------------------
    localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
    localparam logic [7:0] IRQ_IDENTIFY_RST = 8'h01;
    localparam logic [15:0] FRAC_DIVIDER_RST = 16'h0000;
    localparam logic [15:0] STD_DL_RST = 16'h0001;
    localparam logic [2:0] STD_CD_RST = 3'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [EVT_W-1:0] EVT_ZERO = 3'h0;

    // ------------------------
    // field positions
    // ------------------------
    localparam int EN_RX_FULL = 0;
    localparam int EN_TX_EMPTY = 1;
    localparam int EN_LINE = 2;
    localparam int LS_DR = 0;
    localparam int LS_OE = 1;
    localparam int LS_PE = 2;
    localparam int LS_FE = 3;
    localparam int LS_BI = 4;
    localparam int LS_TX_HOLDING_EMPTY = 5;
    localparam int LS_TEMT = 6;
    localparam int FRAC_EN_BIT = 15;
    localparam int FRAC_M_HI = 12;
    localparam int FRAC_M_LO = 11;
    localparam int FRAC_N_HI = 10;
    localparam int STD_CD_LO = 16;
    localparam int STD_CD_HI = 18;
    localparam int EVT_RX = 0;
    localparam int EVT_TX = 1;
    localparam int EVT_LINE = 2;

    // ------------------------
    // identify codes and baud constants
    // ------------------------
    localparam logic [1:0] SRC_LINE = 2'h3;
    localparam logic [1:0] SRC_RX_FULL = 2'h2;
    localparam logic [1:0] SRC_TX_EMPTY = 2'h1;
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [2:0] FRAC_M_ZERO = 3'h4;

endpackage : uif_pkg

// file: uif_baud_gen.sv
// Purpose: 16x oversample tick from integer or fractional divider
// Assumes: divider settings static while in use
// Notes: a divisor latch of zero stops the tick
`timescale 1ns/10ps

module uif_baud_gen #(
    parameter int DL_W = 16,
    parameter int CD_W = 3,
    parameter int N_W = 11
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic frac_en,
    input wire logic [CD_W-1:0] cd,
    input wire logic [DL_W-1:0] dl,
    input wire logic [1:0] frac_m_field,
    input wire logic [N_W-1:0] frac_numerator,
    output logic baud_tick
);

    localparam int PRE_W = DL_W + (1 << CD_W) + 1;

    // ------------------------
    // unit prescaler: 2 * dl * 2^cd clocks
    // ------------------------
    logic [PRE_W-1:0] pre_cnt_q;
    logic [PRE_W-1:0] pre_limit;
    logic unit_pulse;
    logic [2:0] unit_cnt_q;
    logic [2:0] unit_target;
    logic [N_W-1:0] acc_q;
    logic [N_W:0] acc_sum;
    logic [2:0] m_value;

    assign pre_limit = PRE_W'({dl, 1'b0}) << cd;
    assign unit_pulse = (pre_limit != '0) && (pre_cnt_q == pre_limit - PRE_W'(1));

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pre_cnt_q <= '0;
        end else if (clk_en) begin
            pre_cnt_q <= unit_pulse ? '0 : pre_cnt_q + PRE_W'(1);
        end
    end

    // ------------------------
    // fractional stretch: m units, plus one when n/2048 overflows
    // ------------------------
    assign m_value = (frac_m_field == 2'h0) ? uif_pkg::FRAC_M_ZERO : {1'b0, frac_m_field};
    assign acc_sum = {1'b0, acc_q} + {1'b0, frac_numerator};
    assign unit_target = frac_en ? m_value + {2'h0, acc_sum[N_W]} : 3'h1;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            unit_cnt_q <= '0;
            acc_q <= '0;
            baud_tick <= 1'b0;
        end else if (clk_en) begin
            baud_tick <= 1'b0;
            if (unit_pulse) begin
                if (unit_cnt_q + 3'h1 >= unit_target) begin
                    unit_cnt_q <= '0;
                    baud_tick <= 1'b1;
                    if (frac_en) begin
                        acc_q <= acc_sum[N_W-1:0];
                    end
                end else begin
                    unit_cnt_q <= unit_cnt_q + 3'h1;
                end
            end
        end
    end

endmodule : uif_baud_gen

// file: uif_uart_irq_sva.sv
// Purpose: port checks of the uart irq and baud block
// Assumes: one clock, async high reset
// Notes: helpers mirror written config for readback
`timescale 1ns/10ps

module uif_uart_irq_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [uif_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [uif_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [uif_pkg::DATA_W-1:0] reg_rdata,
    input wire logic rx_valid,
    input wire logic rx_break,
    input wire logic tx_take,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic baud_tick
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    wire logic rd_ok = reg_rd && clk_en;
    wire logic id_rd = rd_ok && reg_addr == uif_pkg::ADDR_IRQ_IDENTIFY;
    wire logic ls_rd = rd_ok && reg_addr == uif_pkg::ADDR_LINE_STATUS && !rx_valid && !rx_break;
    wire logic dt_rd = rd_ok && reg_addr == uif_pkg::ADDR_DATA && !rx_valid;
    wire logic dt_wr = reg_wr && clk_en && reg_addr == uif_pkg::ADDR_DATA;
    logic [15:0] frac_q;
    logic [2:0] en_q;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            frac_q <= uif_pkg::FRAC_DIVIDER_RST;
            en_q <= uif_pkg::IRQ_ENABLE_RST[2:0];
        end else if (clk_en && reg_wr) begin
            if (reg_addr == uif_pkg::ADDR_FRAC_DIVIDER)
                frac_q <= reg_wdata[15:0];
            if (reg_addr == uif_pkg::ADDR_IRQ_ENABLE)
                en_q <= reg_wdata[2:0];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_ident_shape: assert property (id_rd |=> reg_rdata[31:3] == '0 &&
        (reg_rdata[0] == (reg_rdata[2:1] == uif_pkg::SRC_NONE))) else $error("identify shape");
    a_tx_load: assert property (dt_wr |=> tx_valid && tx_byte == $past(reg_wdata[7:0]))
        else $error("tx not loaded");
    a_tx_drain: assert property (tx_take && tx_valid && clk_en && !dt_wr |=> !tx_valid)
        else $error("tx not emptied");
    a_line_clear: assert property (ls_rd ##1 ls_rd |=> reg_rdata[4:1] == 4'h0)
        else $error("errors kept");
    a_rx_clear: assert property (dt_rd ##1 ls_rd |=> !reg_rdata[0])
        else $error("ready kept");
    a_ls_shape: assert property (ls_rd |=> reg_rdata[31:7] == '0)
        else $error("status upper bits");
    a_tick_pulse: assert property (baud_tick |=> !baud_tick)
        else $error("tick too long");
    a_frac_back: assert property (rd_ok && reg_addr == uif_pkg::ADDR_FRAC_DIVIDER |=>
        reg_rdata[12:0] == $past(frac_q[12:0]) && reg_rdata[15] == $past(frac_q[15]))
        else $error("fraction readback wrong");
    a_en_back: assert property (rd_ok && reg_addr == uif_pkg::ADDR_IRQ_ENABLE |=>
        reg_rdata[2:0] == $past(en_q)) else $error("enable readback wrong");
    c_line: cover property (id_rd ##1 reg_rdata[2:1] == uif_pkg::SRC_LINE);
    c_tx: cover property (dt_wr ##[1:20] tx_take);
    c_tick: cover property (baud_tick);
endmodule : uif_uart_irq_chk

// file: uif_core_model.sv
// Purpose: receiver and transmitter cores beside the block
// Assumes: characters requested by the bench one at a time
// Notes: unqualified lines toggle so stale values never help
`timescale 1ns/10ps

module uif_core_model #(
    parameter int TAKE_DLY = 6
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic go,
    input wire logic [7:0] go_byte,
    input wire logic go_pe,
    input wire logic go_fe,
    input wire logic tx_valid,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_parity_err,
    output logic rx_frame_err,
    output logic rx_break,
    output logic tx_take,
    output logic tx_shift_busy
);
    int cnt_q;
    assign rx_break = 1'b0;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
            rx_parity_err <= 1'b0;
            rx_frame_err <= 1'b0;
        end else begin
            rx_valid <= go;
            rx_byte <= go ? go_byte : ~rx_byte;
            rx_parity_err <= go ? go_pe : ~rx_parity_err;
            rx_frame_err <= go ? go_fe : ~rx_frame_err;
        end
    end
    // slow take: holding register stays full for a while
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 0;
            tx_take <= 1'b0;
            tx_shift_busy <= 1'b0;
        end else begin
            tx_take <= tx_valid && !tx_take && cnt_q == TAKE_DLY;
            cnt_q <= (tx_valid && !tx_take && cnt_q < TAKE_DLY) ? cnt_q + 1 : 0;
            tx_shift_busy <= tx_take || tx_valid;
        end
    end
endmodule : uif_core_model

// file: tb_uif_uart_irq.sv
// Purpose: self-checking bench of the uart irq and baud block
// Assumes: clk_en held high
// Notes: reads queue expectations, a monitor compares them
`timescale 1ns/10ps

module tb_uif_uart_irq;
    localparam logic [31:0] A_DT = uif_pkg::ADDR_DATA;
    localparam logic [31:0] A_EN = uif_pkg::ADDR_IRQ_ENABLE;
    localparam logic [31:0] A_ID = uif_pkg::ADDR_IRQ_IDENTIFY;
    localparam logic [31:0] A_LS = uif_pkg::ADDR_LINE_STATUS;
    logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata, rnd = 32'hcd0c10e8;
    logic go = 1'b0, go_pe = 1'b0, go_fe = 1'b0, rd_flag = 1'b0;
    logic [7:0] go_byte = 8'h00, rx_byte, tx_byte, b;
    logic rx_valid, rx_parity_err, rx_frame_err, rx_break, tx_take, tx_shift_busy, tx_valid;
    logic baud_tick, uart_irq, evt_irq;
    logic [31:0] exp_q[$], msk_q[$];
    logic [15:0] fv[5] = '{16'h0000, 16'h8000, 16'h9000, 16'h9400, 16'h8800};
    int fs[5] = '{16, 64, 32, 40, 16};
    int eb[3] = '{4, 8, 2};
    int fail_count = 0, checks_done = 0, cyc = 0, n;
    uif_uart_irq i_dut (.sys_clk, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .rx_valid, .rx_byte, .rx_parity_err, .rx_frame_err, .rx_break, .tx_take,
        .tx_shift_busy, .tx_valid, .tx_byte, .baud_tick, .uart_irq, .evt_irq);
    uif_core_model i_core (.sys_clk, .reset, .go, .go_byte, .go_pe, .go_fe, .tx_valid,
        .rx_valid, .rx_byte, .rx_parity_err, .rx_frame_err, .rx_break, .tx_take, .tx_shift_busy);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction : xs
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        checks_done++;
        if (seen !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, seen);
        end
    endtask : chk
    task automatic op(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d,
        input logic [31:0] e, input logic [31:0] m);
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        if (r) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
    endtask : op
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        op(1'b1, 1'b0, a, d, 32'h0, 32'h0);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        op(1'b0, 1'b1, a, xs(), e, m);
    endtask : rd
    task automatic idle(input int c);
        op(1'b0, 1'b0, xs(), xs(), 32'h0, 32'h0);
        repeat (c) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : idle
    // strobes dropped here so a character never rides on a read
    task automatic send(input logic pe, input logic fe);
        @(posedge sys_clk);
        b = 8'(xs());
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        go <= 1'b1;
        go_byte <= b;
        go_pe <= pe;
        go_fe <= fe;
        @(posedge sys_clk);
        go <= 1'b0;
    endtask : send
    task automatic span(output int c);
        int k;
        k = 0;
        c = 0;
        while (k < 3 && c < 400) begin
            @(negedge sys_clk);
            if (k > 0)
                c++;
            if (baud_tick === 1'b1)
                k++;
        end
    endtask : span
    task automatic final_report();
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // ----------------------------------------
    // clock, monitor, timeout, sequence
    // ----------------------------------------
    initial forever #10 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        if (rd_flag)
            chk("reg_rdata", reg_rdata & msk_q.pop_front(), exp_q.pop_front());
        rd_flag = reg_rd;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        rd(A_EN, 32'h0);
        rd(A_ID, 32'h1);
        rd(uif_pkg::ADDR_FRAC_DIVIDER, 32'h0);
        rd(A_LS, 32'h60);
        rd(32'hffff0900, 32'h0);
        wr(A_ID, xs());
        rd(A_ID, 32'h1);
        wr(A_EN, 32'h2);
        rd(A_ID, 32'h2);
        rd(A_ID, 32'h1);
        wr(A_DT, xs());
        rd(A_ID, 32'h1);
        idle(12);
        chk("uart_irq", uart_irq, 1'b1);
        rd(A_ID, 32'h2);
        wr(A_DT, xs());
        rd(A_ID, 32'h1);
        idle(12);
        wr(A_EN, 32'h0);
        idle(3);
        chk("uart_irq", uart_irq, 1'b0);
        send(1'b0, 1'b0);
        idle(4);
        chk("uart_irq", uart_irq, 1'b0);
        wr(A_EN, 32'h5);
        rd(A_EN, 32'h5, 32'h7);
        idle(3);
        chk("uart_irq", uart_irq, 1'b1);
        rd(A_ID, 32'h4);
        rd(A_DT, {24'h0, b}, 32'hff);
        rd(A_ID, 32'h1);
        for (int k = 0; k < 3; k++) begin
            send(k == 0, k == 1);
            if (k == 2)
                send(1'b0, 1'b0);
            idle(4);
            rd(A_ID, 32'h6);
            rd(A_LS, 32'(1 | eb[k]), 32'h1f);
            rd(A_LS, 32'h1, 32'h1f);
            rd(A_ID, 32'h4);
            rd(A_DT, {24'h0, b}, 32'hff);
            rd(A_LS, 32'h0, 32'h1f);
            rd(A_ID, 32'h1);
        end
        wr(uif_pkg::ADDR_EVT_CLEAR, 32'h7);
        wr(uif_pkg::ADDR_EVT_ENABLE, 32'h1);
        idle(3);
        chk("evt_irq", evt_irq, 1'b0);
        send(1'b0, 1'b0);
        idle(4);
        chk("evt_irq", evt_irq, 1'b1);
        rd(uif_pkg::ADDR_EVT_STATUS, 32'h1, 32'h1);
        wr(uif_pkg::ADDR_EVT_CLEAR, 32'h7);
        rd(uif_pkg::ADDR_EVT_CLEAR, 32'h0);
        rd(A_DT, {24'h0, b}, 32'hff);
        idle(3);
        chk("evt_irq", evt_irq, 1'b0);
        rd(uif_pkg::ADDR_EVT_STATUS, 32'h0, 32'h7);
        wr(uif_pkg::ADDR_STD_DIVIDER, 32'h00010002);
        for (int i = 0; i < 5; i++) begin
            wr(uif_pkg::ADDR_FRAC_DIVIDER, {16'h0, fv[i]});
            rd(uif_pkg::ADDR_FRAC_DIVIDER, {16'h0, fv[i]}, 32'h9fff);
            idle(70);
            span(n);
            chk("baud_span", 32'(n), 32'(fs[i]));
        end
        idle(2);
        final_report();
    end
endmodule : tb_uif_uart_irq

bind uif_uart_irq uif_uart_irq_chk i_chk (.sys_clk, .reset, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .rx_valid, .rx_break, .tx_take, .tx_valid, .tx_byte,
    .baud_tick);
